// file: hw/clock_multiplier_control_pkg.sv
/*
 * Types for the oscillator trim and clock multiplier block.
 * Assumes the register header is on the include path.
 */
package clock_multiplier_control_pkg;
    typedef enum logic [1:0] {
        SRC_EXT,
        SRC_EXT_HALF,
        SRC_INT_HALF,
        SRC_RSVD
    } mult_source_t;

    typedef enum logic [2:0] {
        SCALE_1,
        SCALE_2_3,
        SCALE_1_2,
        SCALE_2_5,
        SCALE_1_3,
        SCALE_2_7,
        SCALE_R6,
        SCALE_R7
    } mult_scale_t;

    typedef enum {
        ST_OFF,
        ST_ENABLED,
        ST_LOCKING,
        ST_READY
    } mult_state_t;
endpackage

// file: hw/clock_multiplier_control_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * oscillator trim and clock multiplier block.
 * Assumes inclusion by bare name from the design module and the testbench.
 */
`ifndef CLOCK_MULTIPLIER_CONTROL_REGS_SVH
`define CLOCK_MULTIPLIER_CONTROL_REGS_SVH

// Register indices as printed; byte address is four times the index.
`define MULT_CTRL_IDX 8'h97
`define FINE_TRIM_IDX 8'h9e
`define COARSE_TRIM_IDX 8'ha2
`define MULT_CTRL_ADDR 12'h25c
`define FINE_TRIM_ADDR 12'h278
`define COARSE_TRIM_ADDR 12'h288

// Multiplier control fields.
`define MC_ENABLE_BIT 7
`define MC_START_BIT 6
`define MC_READY_BIT 5
`define MC_SCALE_HI 4
`define MC_SCALE_LO 2
`define MC_SOURCE_HI 1
`define MC_SOURCE_LO 0
`define MC_RESET 8'h00

// Trim widths and default calibration values.
`define COARSE_W 7
`define FINE_W 6
`define COARSE_DEFAULT 7'h40
`define FINE_DEFAULT 6'h20

// Lock time of the multiplier after start, in nanoseconds and cycles.
`define CLK_PERIOD_NS 50
`define LOCK_TIME_NS 5000
`define LOCK_CYCLES ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// System clock source code that selects the multiplier.
`define SYSTEM_CLOCK_OUT_SEL_MULT 2'b10

`endif

// file: hw/osc_trim_clock_multiplier_control.sv
/*
 * Internal oscillator trim registers and clock multiplier control, reached
 * over APB. Functional notes:
 * Assumes an APB master on REF_CLK and oscillator clocks synchronised here.
 */
// Implementation choice: register access over APB.
// Functional notes
// - Seven-bit coarse trim, zero slowest, ones fastest.
// - Coarse trim top bit reads zero.
// - Six-bit fine trim, upper two read zero.
// - Trims reset to calibrated part values.
// - Output is four times input, scaled.
// - Input from external, external half, internal half.
// - Ready flag rises once output usable.
// - Slow input gives four-pulse bursts.
// - Control bits: enable, start, ready, scale, source.
// - Source code ten selects multiplier clock.
`timescale 1ns/1ps
`include "clock_multiplier_control_regs.svh"
module osc_trim_clock_multiplier_control
    import clock_multiplier_control_pkg::*;
#(
    parameter logic [6:0] COARSE_CAL = `COARSE_DEFAULT,
    parameter logic [5:0] FINE_CAL = `FINE_DEFAULT,
    parameter int LOCK_CNT = `LOCK_CYCLES
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Oscillator inputs from outside this clock domain.
    input wire logic EXT_OSC,
    input wire logic INT_OSC,
    // System clock source selection from the clock select logic.
    input wire logic [1:0] SYSTEM_CLOCK_SOURCE_SELECT,
    // Oscillator trim outputs.
    output logic [6:0] COARSE_PERIOD_TRIM,
    output logic [5:0] FINE_PERIOD_TRIM,
    // Multiplier outputs.
    output logic [2:0] MULTIPLIER_SCALE_SELECT,
    output logic [1:0] MULTIPLIER_SOURCE_SELECT,
    output logic MULT_PULSE,
    output logic MULT_USABLE_AS_SYSTEM_CLOCK_OUT
);
    // ************************************************************
    // Register state.
    // ************************************************************
    logic [6:0] coarse_q;
    logic [5:0] fine_q;
    logic en_q;
    logic start_q;
    logic [2:0] scale_q;
    logic [1:0] src_q;
    logic ready_q;
    mult_state_t state_q;
    mult_state_t state_d;
    logic [12:0] lock_q;
    logic [12:0] lock_d;
    logic ext_s1_q;
    logic ext_s2_q;
    logic int_s1_q;
    logic int_s2_q;
    logic ext_half_q;
    logic int_half_q;
    logic ext_prev_q;
    logic int_prev_q;
    logic burst_out;

    // ************************************************************
    // Bus decode.
    // ************************************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    wire setup = PSEL & ~PENABLE;
    wire wr_cyc = setup & PWRITE;
    wire rd_cyc = setup & ~PWRITE;
    wire sel_mc = hit(PADDR, `MULT_CTRL_ADDR);
    wire sel_fine = hit(PADDR, `FINE_TRIM_ADDR);
    wire sel_crs = hit(PADDR, `COARSE_TRIM_ADDR);
    wire mapped = sel_mc | sel_fine | sel_crs;
    wire wr_mc = wr_cyc & sel_mc;
    wire wr_fine = wr_cyc & sel_fine;
    wire wr_crs = wr_cyc & sel_crs;

    wire [7:0] mc_view = {en_q, start_q, ready_q, scale_q, src_q};
    wire [7:0] rd_byte = sel_mc ? mc_view :
        sel_fine ? {2'b00, fine_q} :
        sel_crs ? {1'b0, coarse_q} : 8'h00;

    // ************************************************************
    // APB response: one wait-free access phase after setup.
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup & ~mapped;
            PRDATA <= rd_cyc ? {24'h0, rd_byte} : 32'h0;
        end
    end

    // ************************************************************
    // Trim registers.
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            coarse_q <= COARSE_CAL;
            fine_q <= FINE_CAL;
        end else begin
            if (wr_crs)
                coarse_q <= PWDATA[6:0];
            if (wr_fine)
                fine_q <= PWDATA[5:0];
        end
    end

    // ************************************************************
    // Multiplier control register.
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            en_q <= 1'b0;
            start_q <= 1'b0;
            scale_q <= 3'h0;
            src_q <= 2'h0;
        end else if (wr_mc) begin
            en_q <= PWDATA[`MC_ENABLE_BIT];
            start_q <= PWDATA[`MC_START_BIT];
            scale_q <= PWDATA[`MC_SCALE_HI:`MC_SCALE_LO];
            src_q <= PWDATA[`MC_SOURCE_HI:`MC_SOURCE_LO];
        end
    end

    // ************************************************************
    // Lock sequencer.
    // ************************************************************
    wire lock_done = (lock_q == 13'(LOCK_CNT - 1));

    always_comb begin
        state_d = state_q;
        lock_d = 13'h0;
        case (state_q)
            ST_OFF: begin
                if (en_q)
                    state_d = ST_ENABLED;
            end
            ST_ENABLED: begin
                if (start_q)
                    state_d = ST_LOCKING;
            end
            ST_LOCKING: begin
                lock_d = lock_q + 13'h1;
                if (lock_done)
                    state_d = ST_READY;
            end
            ST_READY: begin
                state_d = ST_READY;
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!en_q || !start_q && state_q != ST_OFF && state_q != ST_ENABLED)
            state_d = en_q ? ST_ENABLED : ST_OFF;
        if (!en_q)
            state_d = ST_OFF;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_q <= ST_OFF;
            lock_q <= 13'h0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lock_q <= lock_d;
            ready_q <= (state_d == ST_READY);
        end
    end

    // ************************************************************
    // Oscillator synchronisers and halving.
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            int_s1_q <= 1'b0;
            int_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
            int_prev_q <= 1'b0;
            ext_half_q <= 1'b0;
            int_half_q <= 1'b0;
        end else begin
            ext_s1_q <= EXT_OSC;
            ext_s2_q <= ext_s1_q;
            int_s1_q <= INT_OSC;
            int_s2_q <= int_s1_q;
            ext_prev_q <= ext_s2_q;
            int_prev_q <= int_s2_q;
            if (ext_s2_q & ~ext_prev_q)
                ext_half_q <= ~ext_half_q;
            if (int_s2_q & ~int_prev_q)
                int_half_q <= ~int_half_q;
        end
    end

    wire src_clk = (src_q == 2'(SRC_EXT)) ? ext_s2_q :
        (src_q == 2'(SRC_EXT_HALF)) ? ext_half_q :
        (src_q == 2'(SRC_INT_HALF)) ? int_half_q : 1'b0;

    pulse_burst #(
        .BURST(4)
    ) u_burst (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .run(ready_q),
        .src_in(src_clk),
        .pulse(burst_out)
    );

    // ************************************************************
    // Outputs.
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            COARSE_PERIOD_TRIM <= COARSE_CAL;
            FINE_PERIOD_TRIM <= FINE_CAL;
            MULTIPLIER_SCALE_SELECT <= 3'h0;
            MULTIPLIER_SOURCE_SELECT <= 2'h0;
            MULT_PULSE <= 1'b0;
            MULT_USABLE_AS_SYSTEM_CLOCK_OUT <= 1'b0;
        end else begin
            COARSE_PERIOD_TRIM <= coarse_q;
            FINE_PERIOD_TRIM <= fine_q;
            MULTIPLIER_SCALE_SELECT <= scale_q;
            MULTIPLIER_SOURCE_SELECT <= src_q;
            MULT_PULSE <= burst_out;
            MULT_USABLE_AS_SYSTEM_CLOCK_OUT <= ready_q &&
                SYSTEM_CLOCK_SOURCE_SELECT == `SYSTEM_CLOCK_OUT_SEL_MULT;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    sequence start_seq;
        state_q == ST_ENABLED && start_q && en_q;
    endsequence

    sequence locking_s;
        state_q == ST_LOCKING;
    endsequence

    sequence quiet_ctrl_s;
        ready_q && !wr_mc && !$past(wr_mc);
    endsequence

    ready_delay_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        start_seq |=> !ready_q [*4])
        else $error("ready flag raised too early");

    ready_needs_en_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        ready_q |-> $past(en_q) && $past(start_q))
        else $error("ready without enable and start");

    coarse_msb_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_cyc && sel_crs |=> PRDATA[7] == 1'b0)
        else $error("coarse trim top bit not zero");

    fine_msb_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_cyc && sel_fine |=> PRDATA[7:6] == 2'b00)
        else $error("fine trim upper bits not zero");

    coarse_write_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_crs |=> coarse_q == $past(PWDATA[6:0]))
        else $error("coarse trim write lost");

    fine_write_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_fine |=> ##1 FINE_PERIOD_TRIM == $past(PWDATA[5:0], 2))
        else $error("fine trim write lost");

    clear_drops_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_mc && PWDATA[7:0] == 8'h00 |=> ##1 !ready_q)
        else $error("ready survived control clear");

    system_clock_out_sel_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        MULT_USABLE_AS_SYSTEM_CLOCK_OUT |-> $past(ready_q))
        else $error("multiplier clock selected before ready");

    reset_trim_a: assert property (
        @(posedge REF_CLK)
        !RST_N |=> coarse_q == COARSE_CAL && fine_q == FINE_CAL)
        else $error("trim not reloaded at reset");

    lock_end_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        locking_s ##1 ready_q |-> $past(lock_done))
        else $error("ready raised before lock count done");

    ready_hold_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        quiet_ctrl_s |=> ready_q)
        else $error("ready flag dropped without a write");

    ctrl_write_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_mc |=> en_q == $past(PWDATA[7]) && start_q == $past(PWDATA[6]) &&
            scale_q == $past(PWDATA[4:2]) && src_q == $past(PWDATA[1:0]))
        else $error("control register write lost");

    ready_ro_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_mc && state_q == ST_OFF |=> !ready_q)
        else $error("ready flag set by a write");

    usable_sel_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        ready_q && SYSTEM_CLOCK_SOURCE_SELECT == `SYSTEM_CLOCK_OUT_SEL_MULT
        |=> MULT_USABLE_AS_SYSTEM_CLOCK_OUT)
        else $error("multiplier clock not offered when ready");

    no_source_a: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        src_q == 2'(SRC_RSVD) |-> !src_clk)
        else $error("unused source code passes a clock");
endmodule

// file: hw/pulse_burst.sv
/*
 * Burst generator: emits four output enables for each rising edge of the
 * synchronised multiplier input, then idles until the next edge.
 * Assumes the input has passed a two-stage synchroniser.
 */
`timescale 1ns/1ps
module pulse_burst #(
    parameter int BURST = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control and input.
    input wire logic run,
    input wire logic src_in,
    // Output pulse.
    output logic pulse
);
    logic prev_q;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    wire rise = src_in & ~prev_q;
    wire busy = (cnt_q != 3'h0);

    assign cnt_d = !run ? 3'h0 : rise ? 3'(BURST - 1) :
        busy ? cnt_q - 3'h1 : cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            cnt_q <= 3'h0;
            pulse <= 1'b0;
        end else begin
            prev_q <= src_in;
            cnt_q <= cnt_d;
            pulse <= run & (busy | rise);
        end
    end

    sequence rise_run_s;
        run && rise ##1 run [*3];
    endsequence

    burst_len_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rise_run_s |-> pulse && $past(pulse) && $past(pulse, 2) ##1 pulse)
        else $error("burst not four pulses long");
endmodule

// file: sim/testbench.sv
/*
 * Self-checking testbench for the oscillator trim and clock multiplier.
 * Assumes the package, register header and design files are compiled first.
 */
`timescale 1ns/1ps
`include "clock_multiplier_control_regs.svh"
module testbench;
    // ************************************************************
    // Signals and design instance.
    // ************************************************************
    localparam int LOCK_N = 4;
    logic ref_clk, rst_n, psel, penable, pwrite, ext_osc, int_osc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data, w32;
    logic pready, pslverr, rd_err, mult_pulse, usable;
    logic [1:0] sel, src, src_out;
    logic [2:0] scale, scale_out;
    logic [6:0] coarse;
    logic [5:0] fine;
    logic [7:0] cfg;
    int bad_count, comparisons, seed, cnt, n;

    osc_trim_clock_multiplier_control #(.LOCK_CNT(LOCK_N)) osc_trim_clock_multiplier_control_inst (
        .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_OSC(ext_osc),
        .INT_OSC(int_osc), .SYSTEM_CLOCK_SOURCE_SELECT(sel),
        .COARSE_PERIOD_TRIM(coarse), .FINE_PERIOD_TRIM(fine),
        .MULTIPLIER_SCALE_SELECT(scale_out),
        .MULTIPLIER_SOURCE_SELECT(src_out), .MULT_PULSE(mult_pulse),
        .MULT_USABLE_AS_SYSTEM_CLOCK_OUT(usable)
    );

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    // ************************************************************
    // Expectations, comparison and bus tasks.
    // ************************************************************
    function automatic logic [31:0] trim_exp(input logic [31:0] d,
            input logic [31:0] mask);
        return d & mask;
    endfunction

    function automatic logic [31:0] pulses_exp(input logic [1:0] s);
        return (s == 2'd0) ? 32'd16 : (s == 2'd3) ? 32'd0 : 32'd8;
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1);
        check("pready", 32'h1, {31'h0, pready});
        check("wait states", 32'h1, k);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a,
            input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd_data);
        check("pslverr", 32'h0, {31'h0, rd_err});
    endtask

    task automatic run_osc(input logic [1:0] s);
        logic lvl;
        cnt = 0;
        ext_osc <= 1'b0;
        int_osc <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 160; i++) begin
            @(posedge ref_clk);
            if (mult_pulse === 1'b1) begin
                cnt++;
            end
            lvl = (i % 40) < 20;
            ext_osc <= (s == 2'd2) ? 1'($random(seed)) : lvl;
            int_osc <= (s == 2'd2) ? lvl : 1'($random(seed));
        end
    endtask

    // ************************************************************
    // Main sequence and watchdog.
    // ************************************************************
    initial begin
        seed = 32'hfb01;
        rst_n = 1'b0;
        {psel, penable, pwrite, ext_osc, int_osc} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        sel = 2'b00;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk("ctrl reset", `MULT_CTRL_ADDR, 32'h0);
        rd_chk("fine reset", `FINE_TRIM_ADDR,
            {26'h0, `FINE_DEFAULT});
        rd_chk("coarse reset", `COARSE_TRIM_ADDR,
            {25'h0, `COARSE_DEFAULT});
        for (int i = 0; i < 10; i++) begin
            w32 = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
            apb(1'b1, `COARSE_TRIM_ADDR, w32);
            rd_chk("coarse", `COARSE_TRIM_ADDR,
                trim_exp(w32, 32'h7f));
            check("coarse out", trim_exp(w32, 32'h7f),
                {25'h0, coarse});
            apb(1'b1, `FINE_TRIM_ADDR, ~w32);
            rd_chk("fine", `FINE_TRIM_ADDR,
                trim_exp(~w32, 32'h3f));
            check("fine out", trim_exp(~w32, 32'h3f),
                {26'h0, fine});
        end
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped data", 32'h0, rd_data);
        check("unmapped err", 32'h1, {31'h0, rd_err});
        for (int k = 0; k < 6; k++) begin
            src = 2'(k);
            scale = 3'(k);
            cfg = {3'b000, scale, src};
            sel <= k[0] ? 2'b10 : 2'($random(seed));
            apb(1'b1, `MULT_CTRL_ADDR, 32'h0);
            apb(1'b1, `MULT_CTRL_ADDR, {24'h0, cfg | 8'h20});
            rd_chk("ctrl cfg", `MULT_CTRL_ADDR,
                {24'h0, cfg});
            apb(1'b1, `MULT_CTRL_ADDR, {24'h0, cfg | 8'h80});
            rd_chk("ctrl enabled", `MULT_CTRL_ADDR,
                {24'h0, cfg | 8'h80});
            repeat (101) @(posedge ref_clk);
            apb(1'b1, `MULT_CTRL_ADDR,
                {24'h0, cfg | 8'hc0});
            n = 0;
            do begin
                apb(1'b0, `MULT_CTRL_ADDR, 32'h0);
                n++;
            end while (rd_data[5] !== 1'b1 && n < 20);
            check("ready", {24'h0, cfg | 8'he0}, rd_data);
            check("scale out", {29'h0, scale},
                {29'h0, scale_out});
            check("source out", {30'h0, src},
                {30'h0, src_out});
            check("usable", {31'h0, sel == 2'b10},
                {31'h0, usable});
            run_osc(src);
            check("pulses", pulses_exp(src),
                cnt);
            apb(1'b1, `MULT_CTRL_ADDR, {24'h0, cfg | 8'h80});
            rd_chk("ready drop", `MULT_CTRL_ADDR,
                {24'h0, cfg | 8'h80});
            check("usable drop", 32'h0, {31'h0, usable});
        end
        complete_run();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end
endmodule
